// [hw/cpu_core_pkg.sv]
// Constants, opcodes and carrier types of the processor sequencing core
package cpu_core_pkg;

	// ****************************************
	// Register port offsets
	// ****************************************
	localparam logic [2:0] REG_FLAGS  = 3'h0;
	localparam logic [2:0] REG_ACCUM  = 3'h1;
	localparam logic [2:0] REG_PC_HI  = 3'h2;
	localparam logic [2:0] REG_PC_LO  = 3'h3;
	localparam logic [2:0] REG_STATUS = 3'h4;
	localparam logic [2:0] REG_SP_HI  = 3'h5;
	localparam logic [2:0] REG_SP_LO  = 3'h6;

	// ****************************************
	// Vectors and reset values
	// ****************************************
	localparam logic [15:0] VEC_RESET     = 16'hFFFE;
	localparam logic [15:0] VEC_SWI       = 16'hFFFC;
	localparam logic [15:0] VEC_SWI_MON   = 16'hFEFC;
	localparam logic [15:0] VEC_IRQ_TOP   = 16'hFFFA;
	localparam logic [15:0] SP_RESET      = 16'h00FF;
	localparam logic [15:0] PC_RESET      = 16'h0000;
	localparam logic [7:0]  FLAGS_RESET   = 8'h68;
	localparam logic [7:0]  BYTE_RESET    = 8'h00;
	localparam logic [2:0]  PUSH_BYTES    = 3'h5;
	localparam logic [2:0]  PULL_LAST     = 3'h4;
	localparam int          STOP_STAB_DEF = 4096;

	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [7:0] OP_SUB_IMM = 8'hA0;
	localparam logic [7:0] OP_AND_IMM = 8'hA4;
	localparam logic [7:0] OP_LDA_IMM = 8'hA6;
	localparam logic [7:0] OP_AIS     = 8'hA7;
	localparam logic [7:0] OP_ADC_IMM = 8'hA9;
	localparam logic [7:0] OP_ADD_IMM = 8'hAB;
	localparam logic [7:0] OP_AIX     = 8'hAF;
	localparam logic [7:0] OP_LSLA    = 8'h48;
	localparam logic [7:0] OP_BRA     = 8'h20;
	localparam logic [7:0] OP_BGE     = 8'h90;
	localparam logic [7:0] OP_BLT     = 8'h91;
	localparam logic [7:0] OP_BGT     = 8'h92;
	localparam logic [7:0] OP_BLE     = 8'h93;
	localparam logic [7:0] OP_RTI     = 8'h80;
	localparam logic [7:0] OP_SWI     = 8'h83;
	localparam logic [7:0] OP_STOP    = 8'h8E;
	localparam logic [7:0] OP_WAIT    = 8'h8F;
	localparam logic [7:0] OP_CLI     = 8'h9A;
	localparam logic [7:0] OP_SEI     = 8'h9B;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic v;
		logic one6;
		logic one5;
		logic h;
		logic i;
		logic n;
		logic z;
		logic c;
	} flags_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  data;
	} mem_req_t;

	typedef struct packed {
		logic       v;
		logic       h;
		logic       c;
		logic [7:0] res;
	} alu_res_t;

	typedef enum logic [2:0] {
		ST_VEC   = 3'b000,
		ST_FETCH = 3'b001,
		ST_OPER  = 3'b010,
		ST_PUSH  = 3'b011,
		ST_PULL  = 3'b100,
		ST_WAIT  = 3'b101,
		ST_STOP  = 3'b110,
		ST_STAB  = 3'b111
	} seq_state_t;

endpackage

// [hw/cpu_flags_and_sequencing.sv]
// Program counter, condition flags, interrupt entry and low-power sequencing
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module cpu_flags_and_sequencing #(
	parameter int IRQ_LINES   = 4,
	parameter int STOP_STAB   = cpu_core_pkg::STOP_STAB_DEF
) (
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   reset,
	// Program memory bus, read data valid while the read strobe is high
	output logic                        memRd,
	output logic                        memWr,
	output logic [15:0]                 memAddr,
	output logic [7:0]                  memWrData,
	input  wire logic [7:0]             memRdData,
	// Interrupt and break sources
	input  wire logic [IRQ_LINES-1:0]   irqReq,
	input  wire logic                   breakReq,
	input  wire logic                   monitorMode,
	// Core status
	output logic                        cpuClkEn,
	output logic                        inBreak,
	// Register port
	input  wire logic [2:0]             regAddr,
	input  wire logic [7:0]             regWrData,
	input  wire logic                   regWr,
	input  wire logic                   regRd,
	output logic [7:0]                  regRdData
);
	import cpu_core_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic alu_res_t addByte(input logic [7:0] a, input logic [7:0] b,
			input logic cin);
		logic [8:0] sum;
		logic [4:0] low;
		alu_res_t   r;
		sum   = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		low   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		r.res = sum[7:0];
		r.c   = sum[8];
		r.h   = low[4];
		r.v   = (a[7] == b[7]) && (sum[7] != a[7]);
		return r;
	endfunction

	function automatic logic [15:0] sext(input logic [7:0] b);
		return {{8{b[7]}}, b};
	endfunction

	function automatic logic [15:0] irqVector(input logic [IRQ_LINES-1:0] req);
		logic [15:0] v;
		v = VEC_IRQ_TOP;
		for (int k = IRQ_LINES - 1; k >= 0; k--) begin
			if (req[k]) begin
				v = VEC_IRQ_TOP - 16'(2 * k);
			end
		end
		return v;
	endfunction

	// ****************************************
	// State
	// ****************************************
	seq_state_t  state_r;
	mem_req_t    mem_r;
	flags_t      flags_r;
	logic [15:0] pc_r;
	logic [15:0] sp_r;
	logic [15:0] hx_r;
	logic [7:0]  acc_r;
	logic [7:0]  instr_r;
	logic [7:0]  hold_r;
	logic [15:0] vec_r;
	logic [2:0]  cnt_r;
	logic [15:0] stab_r;
	logic        clkEn_r;
	logic        break_r;
	logic [7:0]  regRdData_r;
	logic        irqLive;
	logic        signedLess;
	logic        takeBranch;
	alu_res_t    sumRes;
	alu_res_t    difRes;

	assign memRd     = mem_r.rd;
	assign memWr     = mem_r.wr;
	assign memAddr   = mem_r.addr;
	assign memWrData = mem_r.data;
	assign cpuClkEn  = clkEn_r;
	assign inBreak   = break_r;
	assign regRdData = regRdData_r;

	assign irqLive    = (|irqReq) && !flags_r.i;
	assign signedLess = flags_r.n ^ flags_r.v;
	assign sumRes     = addByte(acc_r, memRdData, (instr_r == OP_ADC_IMM) && flags_r.c);
	assign difRes     = addByte(acc_r, ~memRdData, 1'b1);

	always_comb begin
		unique case (instr_r)
			OP_BRA:  takeBranch = 1'b1;
			OP_BGE:  takeBranch = !signedLess;
			OP_BLT:  takeBranch = signedLess;
			OP_BGT:  takeBranch = !(flags_r.z || signedLess);
			OP_BLE:  takeBranch = flags_r.z || signedLess;
			default: takeBranch = 1'b0;
		endcase
	end

	// ****************************************
	// Sequencer and datapath
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_r <= ST_VEC;
			mem_r   <= '{rd: 1'b1, wr: 1'b0, addr: VEC_RESET, data: BYTE_RESET};
			flags_r <= FLAGS_RESET;
			pc_r    <= PC_RESET;
			sp_r    <= SP_RESET;
			hx_r    <= PC_RESET;
			acc_r   <= BYTE_RESET;
			instr_r <= BYTE_RESET;
			hold_r  <= BYTE_RESET;
			vec_r   <= VEC_RESET;
			cnt_r   <= 3'h0;
			stab_r  <= 16'h0000;
			clkEn_r <= 1'b1;
			break_r <= 1'b0;
		end else begin
			// Port writes yield to the core in the same cycle
			if (regWr && regAddr == REG_FLAGS) begin
				flags_r      <= regWrData;
				flags_r.one6 <= 1'b1;
				flags_r.one5 <= 1'b1;
			end
			if (regWr && regAddr == REG_ACCUM) begin
				acc_r <= regWrData;
			end
			mem_r.wr <= 1'b0;
			unique case (state_r)
				ST_VEC: begin
					if (cnt_r == 3'h0) begin
						hold_r     <= memRdData;
						mem_r.addr <= mem_r.addr + 16'h0001;
						cnt_r      <= 3'h1;
					end else begin
						pc_r       <= {hold_r, memRdData};
						mem_r.addr <= {hold_r, memRdData};
						cnt_r      <= 3'h0;
						state_r    <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					if (breakReq) begin
						instr_r  <= OP_SWI;
						vec_r    <= monitorMode ? VEC_SWI_MON : VEC_SWI;
						break_r  <= 1'b1;
						mem_r    <= '{rd: 1'b0, wr: 1'b1, addr: sp_r, data: pc_r[7:0]};
						sp_r     <= sp_r - 16'h0001;
						cnt_r    <= 3'h1;
						state_r  <= ST_PUSH;
					end else if (irqLive) begin
						vec_r    <= irqVector(irqReq);
						mem_r    <= '{rd: 1'b0, wr: 1'b1, addr: sp_r, data: pc_r[7:0]};
						sp_r     <= sp_r - 16'h0001;
						cnt_r    <= 3'h1;
						state_r  <= ST_PUSH;
					end else begin
						instr_r    <= memRdData;
						pc_r       <= pc_r + 16'h0001;
						mem_r.addr <= pc_r + 16'h0001;
						unique case (memRdData)
							OP_SUB_IMM, OP_AND_IMM, OP_LDA_IMM, OP_AIS, OP_ADC_IMM,
							OP_ADD_IMM, OP_AIX, OP_BRA, OP_BGE, OP_BLT, OP_BGT,
							OP_BLE: begin
								state_r <= ST_OPER;
							end
							OP_LSLA: begin
								acc_r     <= {acc_r[6:0], 1'b0};
								flags_r.c <= acc_r[7];
								flags_r.v <= acc_r[7] ^ acc_r[6];
								flags_r.n <= acc_r[6];
								flags_r.z <= (acc_r[6:0] == 7'h00);
							end
							OP_CLI: begin
								flags_r.i <= 1'b0;
							end
							OP_SEI: begin
								flags_r.i <= 1'b1;
							end
							OP_SWI: begin
								vec_r   <= VEC_SWI;
								mem_r   <= '{rd: 1'b0, wr: 1'b1, addr: sp_r,
									data: pc_r[7:0] + 8'h01};
								pc_r    <= pc_r + 16'h0001;
								sp_r    <= sp_r - 16'h0001;
								cnt_r   <= 3'h1;
								state_r <= ST_PUSH;
							end
							OP_RTI: begin
								mem_r.addr <= sp_r + 16'h0001;
								sp_r       <= sp_r + 16'h0001;
								cnt_r      <= 3'h0;
								state_r    <= ST_PULL;
							end
							OP_WAIT: begin
								flags_r.i <= 1'b0;
								clkEn_r   <= 1'b0;
								mem_r.rd  <= 1'b0;
								state_r   <= ST_WAIT;
							end
							OP_STOP: begin
								flags_r.i <= 1'b0;
								clkEn_r   <= 1'b0;
								mem_r.rd  <= 1'b0;
								state_r   <= ST_STOP;
							end
							default: begin
							end
						endcase
					end
				end
				ST_OPER: begin
					pc_r       <= pc_r + 16'h0001;
					mem_r.addr <= pc_r + 16'h0001;
					state_r    <= ST_FETCH;
					unique case (instr_r)
						OP_ADD_IMM, OP_ADC_IMM: begin
							acc_r     <= sumRes.res;
							flags_r.v <= sumRes.v;
							flags_r.h <= sumRes.h;
							flags_r.c <= sumRes.c;
							flags_r.n <= sumRes.res[7];
							flags_r.z <= (sumRes.res == 8'h00);
						end
						OP_SUB_IMM: begin
							acc_r     <= difRes.res;
							flags_r.v <= difRes.v;
							flags_r.c <= !difRes.c;
							flags_r.n <= difRes.res[7];
							flags_r.z <= (difRes.res == 8'h00);
						end
						OP_AND_IMM, OP_LDA_IMM: begin
							acc_r     <= (instr_r == OP_AND_IMM) ? (acc_r & memRdData)
								: memRdData;
							flags_r.v <= 1'b0;
							flags_r.n <= (instr_r == OP_AND_IMM) ? (acc_r[7] & memRdData[7])
								: memRdData[7];
							flags_r.z <= ((instr_r == OP_AND_IMM) ? (acc_r & memRdData)
								: memRdData) == 8'h00;
						end
						OP_AIS: begin
							sp_r <= sp_r + sext(memRdData);
						end
						OP_AIX: begin
							hx_r <= hx_r + sext(memRdData);
						end
						default: begin
							if (takeBranch) begin
								pc_r       <= pc_r + 16'h0001 + sext(memRdData);
								mem_r.addr <= pc_r + 16'h0001 + sext(memRdData);
							end
						end
					endcase
				end
				ST_PUSH: begin
					// Upper index byte stays off the stack
					if (cnt_r != PUSH_BYTES) begin
						mem_r.wr   <= 1'b1;
						mem_r.addr <= sp_r;
						sp_r       <= sp_r - 16'h0001;
						cnt_r      <= cnt_r + 3'h1;
						unique case (cnt_r)
							3'h1:    mem_r.data <= pc_r[15:8];
							3'h2:    mem_r.data <= hx_r[7:0];
							3'h3:    mem_r.data <= acc_r;
							default: mem_r.data <= flags_r;
						endcase
					end else begin
						flags_r.i  <= 1'b1;
						mem_r.rd   <= 1'b1;
						mem_r.addr <= vec_r;
						cnt_r      <= 3'h0;
						state_r    <= ST_VEC;
					end
				end
				ST_PULL: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r != PULL_LAST) begin
						mem_r.addr <= sp_r + 16'h0001;
						sp_r       <= sp_r + 16'h0001;
					end
					unique case (cnt_r)
						3'h0: begin
							flags_r      <= memRdData;
							flags_r.one6 <= 1'b1;
							flags_r.one5 <= 1'b1;
						end
						3'h1: acc_r      <= memRdData;
						3'h2: hx_r[7:0]  <= memRdData;
						3'h3: hold_r     <= memRdData;
						default: begin
							pc_r       <= {hold_r, memRdData};
							mem_r.addr <= {hold_r, memRdData};
							cnt_r      <= 3'h0;
							state_r    <= ST_FETCH;
							if (!breakReq) begin
								break_r <= 1'b0;
							end
						end
					endcase
				end
				ST_WAIT: begin
					if (|irqReq || breakReq) begin
						clkEn_r  <= 1'b1;
						mem_r.rd <= 1'b1;
						state_r  <= ST_FETCH;
					end
				end
				ST_STOP: begin
					if (|irqReq) begin
						stab_r  <= 16'h0000;
						state_r <= ST_STAB;
					end
				end
				ST_STAB: begin
					stab_r <= stab_r + 16'h0001;
					if (stab_r == 16'(STOP_STAB - 1)) begin
						clkEn_r  <= 1'b1;
						mem_r.rd <= 1'b1;
						state_r  <= ST_FETCH;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			regRdData_r <= BYTE_RESET;
		end else if (regRd) begin
			unique case (regAddr)
				REG_FLAGS:  regRdData_r <= flags_r | 8'h60;
				REG_ACCUM:  regRdData_r <= acc_r;
				REG_PC_HI:  regRdData_r <= pc_r[15:8];
				REG_PC_LO:  regRdData_r <= pc_r[7:0];
				REG_STATUS: regRdData_r <= {5'h00, break_r, state_r == ST_STOP
					|| state_r == ST_STAB, state_r == ST_WAIT};
				REG_SP_HI:  regRdData_r <= sp_r[15:8];
				REG_SP_LO:  regRdData_r <= sp_r[7:0];
				default:    regRdData_r <= BYTE_RESET;
			endcase
		end
	end

endmodule

`default_nettype wire

// [bench/cpu_flags_and_sequencing_assertions.sv]
// Port checker of the sequencing core
`timescale 1ns/100ps
`default_nettype none
module cpu_flags_and_sequencing_assertions
	import cpu_core_pkg::*;
#(
	parameter int IRQ_LINES = 4,
	parameter int STOP_STAB = STOP_STAB_DEF
) (
	// Clock and reset
	input wire logic                 clk_sys,
	input wire logic                 reset,
	// Watched ports
	input wire logic                 memRd,
	input wire logic                 memWr,
	input wire logic [15:0]          memAddr,
	input wire logic [7:0]           memRdData,
	input wire logic [IRQ_LINES-1:0] irqReq,
	input wire logic                 breakReq,
	input wire logic                 monitorMode,
	input wire logic                 cpuClkEn,
	input wire logic                 inBreak,
	input wire logic [2:0]           regAddr,
	input wire logic                 regRd,
	input wire logic [7:0]           regRdData
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	logic        stopping_r;
	logic [15:0] wakeCnt_r;
	logic [15:0] irqVec;

	// Expected vector of the lowest-numbered pending request
	always_comb begin
		irqVec = 16'h0000;
		for (int k = IRQ_LINES - 1; k >= 0; k--) begin
			if (irqReq[k]) begin
				irqVec = VEC_IRQ_TOP - 16'(2 * k);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || $rose(cpuClkEn)) begin
			stopping_r <= 1'b0;
		end else if (memRd && cpuClkEn && memRdData == OP_STOP) begin
			stopping_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || cpuClkEn) begin
			wakeCnt_r <= 16'h0000;
		end else if (stopping_r && |irqReq) begin
			wakeCnt_r <= wakeCnt_r + 16'h0001;
		end
	end

	property p_reset_vec;
		disable iff (1'b0) reset |=> memRd && !memWr && memAddr == VEC_RESET && cpuClkEn && !inBreak;
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("reset state wrong");
	property p_vec_order;
		$fell(reset) |-> memAddr == VEC_RESET ##1 memRd && memAddr == 16'hFFFF;
	endproperty
	a_vec_order: assert property (p_vec_order) else $error("reset vector order wrong");
	property p_ais;
		memRd && cpuClkEn && memRdData == OP_AIS |=> memAddr == $past(memAddr) + 16'h0001
			##1 memAddr == $past(memAddr, 2) + 16'h0002;
	endproperty
	a_ais: assert property (p_ais) else $error("stack add not two cycles");
	property p_push_len;
		$rose(memWr) |-> memWr [*5] ##1 !memWr && memRd;
	endproperty
	a_push_len: assert property (p_push_len) else $error("push count wrong");
	property p_push_dec;
		memWr && $past(memWr) |-> memAddr == $past(memAddr) - 16'h0001;
	endproperty
	a_push_dec: assert property (p_push_dec) else $error("push address wrong");
	property p_irq_vec;
		$fell(memWr) && !breakReq |-> memAddr == irqVec;
	endproperty
	a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector wrong");
	property p_brk_vec;
		$fell(memWr) && breakReq |-> memAddr == (monitorMode ? VEC_SWI_MON : VEC_SWI) ##2 inBreak;
	endproperty
	a_brk_vec: assert property (p_brk_vec) else $error("break vector wrong");
	property p_brk_end;
		$fell(inBreak) |-> !$past(breakReq);
	endproperty
	a_brk_end: assert property (p_brk_end) else $error("break ended early");
	property p_wait_wake;
		!cpuClkEn && !stopping_r && |irqReq |-> ##[1:2] cpuClkEn;
	endproperty
	a_wait_wake: assert property (p_wait_wake) else $error("wait wake late");
	property p_stop_stab;
		$rose(cpuClkEn) && stopping_r |-> wakeCnt_r >= STOP_STAB && wakeCnt_r <= STOP_STAB + 3;
	endproperty
	a_stop_stab: assert property (p_stop_stab) else $error("stop wake delay wrong");
	property p_flag_ones;
		regRd && regAddr == REG_FLAGS |=> regRdData[6:5] == 2'b11;
	endproperty
	a_flag_ones: assert property (p_flag_ones) else $error("flag bits 6 5 not one");
endmodule

bind cpu_flags_and_sequencing cpu_flags_and_sequencing_assertions #(
	.IRQ_LINES(IRQ_LINES),
	.STOP_STAB(STOP_STAB)
) checker_inst (
	.clk_sys(clk_sys),
	.reset(reset),
	.memRd(memRd),
	.memWr(memWr),
	.memAddr(memAddr),
	.memRdData(memRdData),
	.irqReq(irqReq),
	.breakReq(breakReq),
	.monitorMode(monitorMode),
	.cpuClkEn(cpuClkEn),
	.inBreak(inBreak),
	.regAddr(regAddr),
	.regRd(regRd),
	.regRdData(regRdData)
);
`default_nettype wire

// [bench/program_memory_model.sv]
// Asynchronous-read program memory on the core bus
`timescale 1ns/100ps
`default_nettype none
module program_memory_model (
	// Clock
	input wire logic        clk_sys,
	// Core memory bus
	input wire logic        memRd,
	input wire logic        memWr,
	input wire logic [15:0] memAddr,
	input wire logic [7:0]  memWrData,
	output logic [7:0]      memRdData
);
	logic [7:0] mem [0:65535];
	logic [7:0] lastRd_r;

	// A released bus shows the inverse of the last byte, never a held value
	always_comb begin
		memRdData = memRd ? mem[memAddr] : ~lastRd_r;
	end

	always @(posedge clk_sys) begin
		if (memRd) begin
			lastRd_r <= mem[memAddr];
		end
		if (memWr) begin
			mem[memAddr] <= memWrData;
		end
	end
endmodule
`default_nettype wire

// [bench/test_cpu_flags_and_sequencing.sv]
// Self-checking bench of the sequencing core
`timescale 1ns/100ps
`default_nettype none
module test_cpu_flags_and_sequencing;
	import cpu_core_pkg::*;
	logic        clk_sys, reset, memRd, memWr, cpuClkEn, inBreak;
	logic        breakReq, monitorMode, regWr, regRd;
	logic [15:0] memAddr;
	logic [7:0]  memWrData, memRdData, regWrData, regRdData, got;
	logic [3:0]  irqReq;
	logic [2:0]  regAddr;
	int          fail_count, checks_done, cycles;
	logic [7:0]  prog [21] = '{8'hA6, 8'h7F, 8'hAB, 8'h01, 8'hAB, 8'h80, 8'hA7, 8'hFE, 8'hAF,
		8'h05, 8'h9D, 8'h9D, 8'h9D, 8'h9D, 8'h9D, 8'h9D, 8'h9A, 8'h9D, 8'h9D, 8'h8F, 8'h8E};
	logic [7:0]  stk [6] = '{8'h11, 8'h10, 8'h05, 8'h00, 8'hE3, 8'h9D};
	// Subtract, logic, shift and every branch kind, then wait at 1116
	logic [7:0]  prog2 [23] = '{8'hA6, 8'h80, 8'hA0, 8'h01, 8'h91, 8'h02, 8'hA6, 8'h55, 8'h90,
		8'h02, 8'hA4, 8'hC1, 8'h48, 8'h92, 8'h02, 8'hA6, 8'h55, 8'h93, 8'h02, 8'h20, 8'h01,
		8'h48, 8'h8F};

	cpu_flags_and_sequencing #(.IRQ_LINES(4), .STOP_STAB(8)) cpu_flags_and_sequencing_inst (
		.clk_sys(clk_sys), .reset(reset), .memRd(memRd), .memWr(memWr),
		.memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData),
		.irqReq(irqReq), .breakReq(breakReq), .monitorMode(monitorMode),
		.cpuClkEn(cpuClkEn), .inBreak(inBreak), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
	program_memory_model program_memory_model_inst (.clk_sys(clk_sys), .memRd(memRd),
		.memWr(memWr), .memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic poke(input int a, input logic [7:0] d);
		program_memory_model_inst.mem[a] = d;
	endtask
	task automatic regAccess(input logic [2:0] a, input logic wr, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWr <= wr;
		regRd <= !wr;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
		regRd <= 1'b0;
		@(negedge clk_sys);
		got = regRdData;
	endtask
	task automatic readExp(input logic [2:0] a, input logic [7:0] exp, input string what);
		regAccess(a, 1'b0, 8'h00);
		check8(what, exp, got);
	endtask
	// Waits for a read at address a, or for the core clock to stop
	task automatic waitFor(input logic onClk, input logic [15:0] a);
		int n;
		n = 0;
		while (!(onClk ? cpuClkEn === 1'b0 : memRd === 1'b1 && memAddr === a) && n < 300) begin
			@(negedge clk_sys);
			n++;
		end
		check8("wait outcome", 8'h00, 8'(n / 300));
	endtask
	task automatic setIrq(input logic [3:0] v);
		@(posedge clk_sys);
		irqReq <= v;
	endtask
	task automatic summarize;
		if (fail_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 4000) begin
			fail_count++;
			$display("unexpected run length: expected below 4000, seen 4000");
			summarize();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{reset, breakReq, monitorMode, regWr, regRd} = 5'b10000;
		{irqReq, regAddr, regWrData} = 15'h0000;
		{cycles, fail_count, checks_done} = '0;
		for (int i = 0; i < 65536; i++) poke(i, 8'h9D);
		for (int i = 0; i < 21; i++) poke(16'h1000 + i, prog[i]);
		for (int v = 16'hFFF4; v < 16'hFFFE; v += 2) poke(v, 8'h20);
		for (int v = 16'hFFF5; v < 16'hFFFE; v += 2) poke(v, 8'h00);
		{program_memory_model_inst.mem[16'hFEFC], program_memory_model_inst.mem[16'hFEFD]} = 16'h2000;
		{program_memory_model_inst.mem[16'hFFFE], program_memory_model_inst.mem[16'hFFFF]} = 16'h1000;
		poke(16'h2000, OP_RTI);
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		readExp(REG_FLAGS, 8'h68, "flags after reset");
		waitFor(1'b0, 16'h1004);
		readExp(REG_FLAGS, 8'hFC, "flags of 7F plus 01");
		waitFor(1'b0, 16'h1006);
		readExp(REG_FLAGS, 8'hEB, "flags of 80 plus 80");
		waitFor(1'b0, 16'h1008);
		readExp(REG_ACCUM, 8'h00, "accumulator");
		waitFor(1'b0, 16'h100A);
		readExp(REG_SP_LO, 8'hFD, "stack pointer low");
		setIrq(4'h6);
		waitFor(1'b0, 16'h1010);
		check8("stack while masked", 8'h9D, program_memory_model_inst.mem[16'h00FD]);
		waitFor(1'b0, 16'hFFF8);
		setIrq(4'h0);
		foreach (stk[i]) begin
			check8("stacked byte", stk[i], program_memory_model_inst.mem[16'h00FD - i]);
		end
		waitFor(1'b0, 16'h1011);
		readExp(REG_FLAGS, 8'hE3, "flags after return");
		waitFor(1'b1, 16'h0000);
		readExp(REG_STATUS, 8'h01, "status in wait");
		regAccess(REG_FLAGS, 1'b1, 8'h00);
		readExp(REG_FLAGS, 8'h60, "flags after port write");
		regAccess(REG_PC_HI, 1'b1, 8'hAA);
		readExp(REG_PC_HI, 8'h10, "program counter high");
		readExp(3'h7, 8'h00, "unmapped register");
		setIrq(4'h1);
		waitFor(1'b0, 16'hFFFA);
		setIrq(4'h0);
		waitFor(1'b0, 16'h1014);
		waitFor(1'b1, 16'h0000);
		readExp(REG_STATUS, 8'h02, "status in stop");
		setIrq(4'h8);
		waitFor(1'b0, 16'hFFF4);
		setIrq(4'h0);
		waitFor(1'b0, 16'h1015);
		readExp(REG_FLAGS, 8'h60, "flags after stop wake");
		for (int m = 0; m < 2; m++) begin
			@(posedge clk_sys);
			monitorMode <= m[0];
			breakReq <= 1'b1;
			waitFor(1'b0, m ? VEC_SWI_MON : VEC_SWI);
			// Break request drops before the handler's return is fetched
			@(posedge clk_sys);
			breakReq <= 1'b0;
			readExp(REG_STATUS, 8'h04, "status in break");
			repeat (12) @(posedge clk_sys);
			readExp(REG_STATUS, 8'h00, "status after break");
		end
		// ****************************************
		// Second program after a reset in mid-run
		// ****************************************
		foreach (prog2[i]) poke(16'h1100 + i, prog2[i]);
		poke(16'hFFFE, 8'h11);
		poke(16'hFFFF, 8'h00);
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		waitFor(1'b1, 16'h0000);
		readExp(REG_ACCUM, 8'h82, "accumulator after branches");
		readExp(REG_FLAGS, 8'hE4, "flags after shift");
		readExp(REG_PC_LO, 8'h17, "program counter low in wait");
		// Wake from wait by reset sets the mask again
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		readExp(REG_FLAGS, 8'h68, "flags after reset in wait");
		readExp(REG_STATUS, 8'h00, "status after reset in wait");
		summarize();
	end
endmodule
`default_nettype wire
